// File: logic/shc_serial_clock_divider.sv
// Purpose: serial clock generation, input filters and word framing for the serial host port
// Assumes: clock polarity 0, words of 24 bits sent msb first
// Notes: pins pass three flops, sclk and sda filters then reject spikes by mode
`timescale 1ns/1ps
module shc_serial_clock_divider (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire shc_pkg::shc_cfg_s cfg,
  input wire logic [shc_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic host_request_n,
  input wire logic sclk_i,
  input wire logic sda_i,
  input wire logic ss_n_i,
  output logic sclk_o,
  output logic sclk_oe,
  output logic sdo_o,
  output logic sdo_oe,
  output logic scl_filt,
  output logic sda_filt,
  output logic busy,
  output logic ratio_low,
  output logic i2c_over_rate,
  output logic [shc_pkg::PER_W-1:0] period_cycles
);
  function automatic logic [shc_pkg::PER_W-1:0] half_cycles(input logic [shc_pkg::MOD_W-1:0] m, input logic byp);
    half_cycles = (shc_pkg::PER_W'(m) + 11'h001) * (byp ? 11'h001 : shc_pkg::PRESCALE_DIV);
  endfunction : half_cycles

  function automatic logic [4:0] filt_len(input shc_pkg::shc_filt_e mode);
    unique case (mode)
      shc_pkg::SHC_FILT_BYPASS: filt_len = 5'h00;
      shc_pkg::SHC_FILT_NARROW: filt_len = shc_pkg::NARROW_CYC;
      shc_pkg::SHC_FILT_WIDE: filt_len = shc_pkg::WIDE_CYC;
      default: filt_len = shc_pkg::WIDE_CYC;
    endcase
  endfunction : filt_len

  logic [shc_pkg::WORD_W-1:0] f_data;
  logic f_valid, f_pop;
  shc_fifo #(.WIDTH(shc_pkg::WORD_W), .DEPTH(shc_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // pin filters: 0 sclk, 1 sda, 2 select, 3 host request
  logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
  logic [4:0] fcnt_q [4];
  logic [4:0] fcnt_d [4];
  logic [4:0] len [4];

  always_comb begin
    len[0] = filt_len(cfg.filter_mode);
    len[1] = filt_len(cfg.filter_mode);
    len[2] = 5'h00;
    len[3] = 5'h00;
    for (int i = 0; i < 4; i++) begin
      filt_d[i] = filt_q[i];
      fcnt_d[i] = 5'h00;
      if (s2_q[i] == s3_q[i] && s3_q[i] != filt_q[i]) begin
        if (len[i] == 5'h00 || fcnt_q[i] == len[i] - 5'h01) begin
          filt_d[i] = s3_q[i];
        end else begin
          fcnt_d[i] = fcnt_q[i] + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      s3_q <= 4'hF;
      filt_q <= 4'hF;
      prev_q <= 4'hF;
      for (int i = 0; i < 4; i++) begin
        fcnt_q[i] <= 5'h00;
      end
    end else begin
      s1_q <= {host_request_n, ss_n_i, sda_i, sclk_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
      for (int i = 0; i < 4; i++) begin
        fcnt_q[i] <= fcnt_d[i];
      end
    end
  end

  assign scl_filt = filt_q[0];
  assign sda_filt = filt_q[1];

  logic [shc_pkg::PER_W-1:0] half;
  assign half = half_cycles(cfg.divider_modulus, cfg.prescaler_bypass);
  assign period_cycles = {half[shc_pkg::PER_W-2:0], 1'b0};
  // i2c range and ratio limits are left to software, only flagged here
  assign ratio_low = (period_cycles < shc_pkg::RATIO_MIN) ||
                     (cfg.i2c_mode && period_cycles < shc_pkg::I2C_MIN_PERIOD);
  assign i2c_over_rate = cfg.i2c_mode && (period_cycles < shc_pkg::I2C_FAST_CYC);

  // master engine
  shc_pkg::shc_state_e st_q, st_d;
  logic [2:0] pre_q, pre_d;
  logic [shc_pkg::MOD_W-1:0] div_q, div_d;
  logic [shc_pkg::PER_W-1:0] lead_q, lead_d, since_q, since_d;
  logic [5:0] edge_q, edge_d;
  logic [4:0] sbit_q, sbit_d;
  logic [shc_pkg::WORD_W-1:0] sh_q, sh_d;
  logic sclk_q, sclk_d, sdo_q, sdo_d;
  logic tick, half_tick, host_request_line_ok, m_start, m_toggle, s_rise, s_fall, s_sample, s_present, s_load, ss_fall;

  assign tick = cfg.prescaler_bypass || (pre_q == shc_pkg::PRESCALE_LAST);
  assign half_tick = tick && (div_q == cfg.divider_modulus);
  assign host_request_line_ok = !cfg.host_request_line_en || !filt_q[3];
  assign m_start = (st_q == shc_pkg::SHC_IDLE) && cfg.master && !cfg.i2c_mode && f_valid && host_request_line_ok;
  assign m_toggle = (st_q == shc_pkg::SHC_SHIFT) && half_tick;
  assign s_rise = filt_q[0] && !prev_q[0];
  assign s_fall = !filt_q[0] && prev_q[0];
  assign ss_fall = !filt_q[2] && prev_q[2];
  assign s_sample = !cfg.master && !filt_q[2] && (cfg.cpha ? s_fall : s_rise);
  assign s_present = !cfg.master && !filt_q[2] && (cfg.cpha ? s_rise : s_fall);
  // a held-low select still reloads on the word count
  assign s_load = !cfg.master && !cfg.i2c_mode && (ss_fall || (s_sample && sbit_q == shc_pkg::LAST_BIT));
  assign f_pop = f_valid && (m_start || s_load);

  always_comb begin
    st_d = st_q;
    pre_d = tick ? 3'h0 : pre_q + 3'h1;
    // a lowered modulus must not leave the count stranded above it
    div_d = (half_tick || div_q > cfg.divider_modulus) ? '0 : (tick ? div_q + 1'b1 : div_q);
    lead_d = lead_q;
    edge_d = edge_q;
    since_d = since_q + 11'h001;
    sbit_d = sbit_q;
    sh_d = sh_q;
    sclk_d = sclk_q;
    sdo_d = sdo_q;
    unique case (st_q)
      shc_pkg::SHC_IDLE: begin
        if (m_start) begin
          st_d = shc_pkg::SHC_LEAD;
          lead_d = half + shc_pkg::HOST_REQUEST_LINE_FIXED_CYC + shc_pkg::HOST_REQUEST_LINE_MARGIN_CYC;
          edge_d = 6'h00;
          sclk_d = 1'b0;
          sh_d = f_data;
          if (!cfg.cpha) begin
            sdo_d = f_data[shc_pkg::WORD_W-1];
            sh_d = {f_data[shc_pkg::WORD_W-2:0], 1'b0};
          end
        end
      end
      shc_pkg::SHC_LEAD: begin
        lead_d = lead_q - 11'h001;
        if (lead_q == 11'h001) begin
          st_d = shc_pkg::SHC_SHIFT;
          pre_d = 3'h0;
          div_d = '0;
          since_d = '0;
        end
      end
      shc_pkg::SHC_SHIFT: begin
        if (m_toggle) begin
          sclk_d = !sclk_q;
          since_d = '0;
          edge_d = edge_q + 6'h01;
          // leading edges present data in phase 1, trailing ones in phase 0
          if (cfg.cpha != sclk_q) begin
            sdo_d = sh_q[shc_pkg::WORD_W-1];
            sh_d = {sh_q[shc_pkg::WORD_W-2:0], 1'b0};
          end
          if (edge_q == shc_pkg::LAST_EDGE) begin
            st_d = shc_pkg::SHC_IDLE;
          end
        end
      end
    endcase
    if (s_sample) begin
      sbit_d = (sbit_q == shc_pkg::LAST_BIT) ? 5'h00 : sbit_q + 5'h01;
    end
    if (filt_q[2]) begin
      sbit_d = 5'h00;
    end
    if (s_load) begin
      sbit_d = ss_fall ? 5'h00 : sbit_d;
      // empty fifo sends zeros rather than stale bits
      sh_d = f_valid ? f_data : '0;
      if (!cfg.cpha) begin
        sdo_d = sh_d[shc_pkg::WORD_W-1];
        sh_d = {sh_d[shc_pkg::WORD_W-2:0], 1'b0};
      end
    end else if (s_present) begin
      sdo_d = sh_q[shc_pkg::WORD_W-1];
      sh_d = {sh_q[shc_pkg::WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= shc_pkg::SHC_IDLE;
      pre_q <= 3'h0;
      div_q <= '0;
      lead_q <= '0;
      since_q <= '0;
      edge_q <= 6'h00;
      sbit_q <= 5'h00;
      sh_q <= '0;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      div_q <= div_d;
      lead_q <= lead_d;
      since_q <= since_d;
      edge_q <= edge_d;
      sbit_q <= sbit_d;
      sh_q <= sh_d;
      sclk_q <= sclk_d;
      sdo_q <= sdo_d;
    end
  end

  assign sclk_o = sclk_q;
  // i2c clock is open drain: enable only while pulling low
  assign sclk_oe = cfg.master && (!cfg.i2c_mode || !sclk_q);
  assign sdo_o = sdo_q;
  assign sdo_oe = !cfg.i2c_mode && (cfg.master ? (st_q != shc_pkg::SHC_IDLE) : !filt_q[2]);
  assign busy = (st_q != shc_pkg::SHC_IDLE);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_half_period;
    m_toggle |-> since_q == half - 11'h001;
  endproperty
  a_half_period: assert property (p_half_period) else $error("serial clock half period wrong");

  property p_prescale;
    (tick && !cfg.prescaler_bypass) |=> (!tick || cfg.prescaler_bypass) [*7];
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler ticked early");

  property p_div_range;
    $stable(cfg.divider_modulus) |-> div_q <= cfg.divider_modulus;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divider passed modulus");

  property p_period_range;
    period_cycles >= 11'h002 && period_cycles <= 11'h400 && (period_cycles != 11'h400 || cfg.divider_modulus == 6'h3F);
  endproperty
  a_period_range: assert property (p_period_range) else $error("period out of range");

  property p_lead_wait;
    (st_q == shc_pkg::SHC_IDLE && st_d == shc_pkg::SHC_LEAD) |=> $stable(sclk_q) [*5];
  endproperty
  a_lead_wait: assert property (p_lead_wait) else $error("first edge too soon after request");

  property p_lead_len;
    (st_q == shc_pkg::SHC_IDLE && st_d == shc_pkg::SHC_LEAD) |=> lead_q == $past(half) + 11'h004;
  endproperty
  a_lead_len: assert property (p_lead_len) else $error("start delay count wrong");

  property p_narrow;
    (cfg.filter_mode == shc_pkg::SHC_FILT_NARROW && $stable(cfg.filter_mode) && $changed(filt_q[0])) |->
      $past(s3_q[0], 5) == filt_q[0];
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow filter passed a spike");

  property p_wrap;
    (s_sample && sbit_q == shc_pkg::LAST_BIT && !ss_fall && !filt_q[2]) |=> sbit_q == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("slave word count did not wrap");

  property p_reload;
    (s_load && f_valid) |-> f_pop;
  endproperty
  a_reload: assert property (p_reload) else $error("slave missed word reload");

  c_master_word: cover property (st_q == shc_pkg::SHC_SHIFT && m_toggle && edge_q == shc_pkg::LAST_EDGE);
  c_slave_back: cover property (s_load && !ss_fall && cfg.cpha);
  c_wide_filter: cover property (cfg.filter_mode == shc_pkg::SHC_FILT_WIDE && $changed(filt_q[1]));
endmodule : shc_serial_clock_divider

// File: logic/shc_pkg.sv
// Purpose: shared constants and types for the serial host clock divider
// Assumes: 250 MHz system clock, 24-bit serial words
// Notes: figures live here and the logic uses the names, assertions and the bench repeat some as literals
package shc_pkg;
  localparam int SYS_CLK_PS = 4000;
  localparam int SYS_CLK_MHZ = 250;
  localparam int WORD_W = 24;
  localparam int FIFO_DEPTH = 32;
  localparam int MOD_W = 6;
  localparam int PER_W = 11;
  localparam logic [PER_W-1:0] PRESCALE_DIV = 11'h008;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [5:0] MOD_MAX = 6'h3F;
  localparam logic [5:0] LAST_EDGE = 6'h2F;
  localparam logic [4:0] LAST_BIT = 5'h17;
  // spike widths in ns, filter lengths are least times so round up
  localparam int NARROW_SPIKE_NS = 20;
  localparam int WIDE_SPIKE_NS = 100;
  localparam logic [4:0] NARROW_CYC = 5'((NARROW_SPIKE_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS);
  localparam logic [4:0] WIDE_CYC = 5'((WIDE_SPIKE_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS);
  // host request start-up: fixed two cycles plus a margin in ns
  localparam logic [PER_W-1:0] HOST_REQUEST_LINE_FIXED_CYC = 11'h002;
  localparam int HOST_REQUEST_LINE_MARGIN_NS = 6;
  localparam logic [PER_W-1:0] HOST_REQUEST_LINE_MARGIN_CYC = PER_W'((HOST_REQUEST_LINE_MARGIN_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS);
  // clock ratio limits
  localparam int RATIO_SPLIT_MHZ = 33;
  localparam logic [PER_W-1:0] RATIO_MIN_LOW = 11'h004;
  localparam logic [PER_W-1:0] RATIO_MIN_HIGH = 11'h006;
  localparam logic [PER_W-1:0] RATIO_MIN = (SYS_CLK_MHZ > RATIO_SPLIT_MHZ) ? RATIO_MIN_HIGH : RATIO_MIN_LOW;
  localparam logic [PER_W-1:0] I2C_MIN_PERIOD = 11'h006;
  localparam int I2C_STD_KHZ = 100;
  localparam int I2C_FAST_KHZ = 1000;
  localparam logic [PER_W-1:0] I2C_FAST_CYC = PER_W'(SYS_CLK_MHZ * 1000 / I2C_FAST_KHZ);
  localparam logic [PER_W-1:0] I2C_STD_CYC = PER_W'(SYS_CLK_MHZ * 1000 / I2C_STD_KHZ);

  typedef enum logic [1:0] {
    SHC_FILT_BYPASS = 2'h0,
    SHC_FILT_NARROW = 2'h1,
    SHC_FILT_WIDE = 2'h3
  } shc_filt_e;

  typedef enum logic [1:0] {
    SHC_IDLE = 2'h0,
    SHC_LEAD = 2'h1,
    SHC_SHIFT = 2'h3
  } shc_state_e;

  // serial_clock_control_reg contents plus mode bits
  typedef struct packed {
    logic [MOD_W-1:0] divider_modulus;
    logic prescaler_bypass;
    shc_filt_e filter_mode;
    logic i2c_mode;
    logic master;
    logic cpha;
    logic host_request_line_en;
  } shc_cfg_s;
endpackage : shc_pkg

// File: logic/shc_fifo.sv
// Purpose: synchronous valid/ready FIFO for transmit words
// Assumes: single clock, depth a power of two
// Notes: read data comes straight from the storage flops
`timescale 1ns/1ps
module shc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset: contents are never read while empty
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : shc_fifo

// File: testbench/shc_partner.sv
// Purpose: far-side spi peer for the serial host clock divider
// Assumes: clock polarity 0, 24-bit words sent msb first
// Notes: captures master words, can also act as spi master
`timescale 1ns/1ps
module shc_partner (
  input wire logic sclk_o,
  input wire logic sdo_o,
  output logic host_request_n,
  output logic sclk_i,
  output logic sda_i,
  output logic ss_n_i
);
  logic [shc_pkg::WORD_W-1:0] rx_q [$];
  logic [shc_pkg::WORD_W-1:0] sh = '0;
  int cnt = 0;

  initial begin
    host_request_n = 1'b1;
    sclk_i = 1'b0;
    // pulled up while released
    sda_i = 1'b1;
    ss_n_i = 1'b1;
  end

  task automatic take(input logic b);
    sh = {sh[shc_pkg::WORD_W-2:0], b};
    cnt++;
    if (cnt == shc_pkg::WORD_W) begin
      rx_q.push_back(sh);
      cnt = 0;
    end
  endtask : take

  // slave side of a master transfer, cpha 0 samples on the rise
  always @(posedge sclk_o) begin
    take(sdo_o);
  end

  // master of a cpha 1 slave; select stays low between words
  task automatic exchange(input int half_ns, input int words);
    ss_n_i = 1'b0;
    repeat (words * shc_pkg::WORD_W) begin
      #(half_ns);
      sclk_i = 1'b1;
      #(half_ns);
      take(sdo_o);
      sclk_i = 1'b0;
    end
    #(half_ns);
    ss_n_i = 1'b1;
  endtask : exchange
endmodule : shc_partner

// File: testbench/testbench.sv
// Purpose: self-checking bench for the serial host clock divider
// Assumes: 250 MHz clock, xorshift stimulus seeded at 65
// Notes: the partner model stands at the serial pins
`timescale 1ns/1ps
module testbench;
  logic sys_clk;
  logic rst_n;
  shc_pkg::shc_cfg_s cfg;
  logic [shc_pkg::WORD_W-1:0] tx_data;
  logic tx_valid, tx_ready, host_request_n, sclk_i, sda_i, ss_n_i;
  logic sclk_o, sclk_oe, sdo_o, sdo_oe, scl_filt, sda_filt, busy, ratio_low, i2c_over_rate;
  logic [shc_pkg::PER_W-1:0] period_cycles;
  logic [shc_pkg::WORD_W-1:0] exp_q [$];
  logic [6:0] corner [4] = '{7'h01, 7'h05, 7'h7E, 7'h7F};
  logic [31:0] rng = 32'h0000_0041;
  int error_cnt = 0;
  int samples_checked = 0;
  int p;

  shc_serial_clock_divider shc_serial_clock_divider_i (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .host_request_n(host_request_n),
    .sclk_i(sclk_i), .sda_i(sda_i), .ss_n_i(ss_n_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .scl_filt(scl_filt), .sda_filt(sda_filt), .busy(busy), .ratio_low(ratio_low),
    .i2c_over_rate(i2c_over_rate), .period_cycles(period_cycles));

  shc_partner shc_partner_i (.sclk_o(sclk_o), .sdo_o(sdo_o), .host_request_n(host_request_n),
    .sclk_i(sclk_i), .sda_i(sda_i), .ss_n_i(ss_n_i));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic int exp_per(input logic [5:0] m, input logic b);
    return 2 * (m + 1) * (b ? 1 : 8);
  endfunction : exp_per

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic cmp_words();
    check("word count", exp_q.size(), shc_partner_i.rx_q.size());
    while (exp_q.size() > 0 && shc_partner_i.rx_q.size() > 0)
      check("serial word", exp_q.pop_front(), shc_partner_i.rx_q.pop_front());
    exp_q.delete();
    shc_partner_i.rx_q.delete();
  endtask : cmp_words

  // master run; request held off while filling so the fifo fills up
  task automatic burst(input logic [5:0] m, input logic b, input int words);
    int n;
    int per;
    realtime t0;
    @(negedge sys_clk);
    cfg = '0;
    cfg.divider_modulus = m;
    cfg.prescaler_bypass = b;
    cfg.master = 1'b1;
    cfg.host_request_line_en = 1'b1;
    tx_valid = 1'b1;
    for (n = 0; n < words; n++) begin
      tx_data = shc_pkg::WORD_W'(xs());
      #1;
      if (tx_ready !== 1'b1) break;
      exp_q.push_back(tx_data);
      @(negedge sys_clk);
    end
    tx_valid = 1'b0;
    if (words > shc_pkg::FIFO_DEPTH) check("words accepted", shc_pkg::FIFO_DEPTH, n);
    per = 4 * exp_per(m, b);
    t0 = $realtime;
    shc_partner_i.host_request_n = 1'b0;
    @(posedge sclk_o);
    n = int'($realtime - t0);
    check("first edge delay", 1, n >= per / 2 + 14 && n <= per + 60);
    t0 = $realtime;
    @(posedge sclk_o);
    check("sclk period ns", per, int'($realtime - t0));
    @(negedge sys_clk);
    check("sdo_oe in word", 1, sdo_oe);
    check("sclk_oe in word", 1, sclk_oe);
    // drop the request now and then to stall between words
    for (n = 0; n < 20000 && shc_partner_i.rx_q.size() < exp_q.size(); n++) begin
      @(negedge sys_clk);
      shc_partner_i.host_request_n = (n % 3000) > 2700;
    end
    shc_partner_i.host_request_n = 1'b1;
    repeat (200) @(negedge sys_clk);
    check("busy after drain", 0, busy);
    check("tx_ready after drain", 1, tx_ready);
    check("sdo_oe after drain", 0, sdo_oe);
    check("sda_filt idle", 1, sda_filt);
    cmp_words();
  endtask : burst

  task automatic filt_try(input shc_pkg::shc_filt_e fm, input int w, input logic exp);
    logic seen;
    seen = 1'b0;
    cfg.filter_mode = fm;
    repeat (40) @(negedge sys_clk);
    shc_partner_i.sclk_i = 1'b1;
    #(w);
    shc_partner_i.sclk_i = 1'b0;
    repeat (60) begin
      @(negedge sys_clk);
      seen |= scl_filt;
    end
    check("scl_filt pulse seen", exp, seen);
  endtask : filt_try

  initial begin
    #120_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    cfg = '0;
    tx_data = '0;
    tx_valid = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    // divider corners then random codes
    for (int i = 0; i < 48; i++) begin
      @(negedge sys_clk);
      {cfg.divider_modulus, cfg.prescaler_bypass} = (i < 4) ? corner[i] : 7'(xs());
      cfg.i2c_mode = (i < 4) ? 1'b1 : 1'(xs());
      #1;
      p = exp_per(cfg.divider_modulus, cfg.prescaler_bypass);
      check("period_cycles", p, period_cycles);
      check("ratio_low", p < 6, ratio_low);
      check("i2c_over_rate", cfg.i2c_mode && p < 250, i2c_over_rate);
    end
    burst(6'h02, 1'b1, 40);
    burst(6'h00, 1'b0, 1);
    // slave with phase 1, words queued before the first edge
    @(negedge sys_clk);
    cfg = '0;
    cfg.cpha = 1'b1;
    tx_valid = 1'b1;
    repeat (2) begin
      tx_data = shc_pkg::WORD_W'(xs());
      exp_q.push_back(tx_data);
      @(negedge sys_clk);
    end
    tx_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    shc_partner_i.exchange(32, 2);
    cmp_words();
    repeat (8) @(negedge sys_clk);
    check("sdo_oe released", 0, sdo_oe);
    filt_try(shc_pkg::SHC_FILT_BYPASS, 12, 1'b1);
    filt_try(shc_pkg::SHC_FILT_NARROW, 12, 1'b0);
    filt_try(shc_pkg::SHC_FILT_WIDE, 80, 1'b0);
    filt_try(shc_pkg::SHC_FILT_NARROW, 200, 1'b1);
    filt_try(shc_pkg::SHC_FILT_WIDE, 200, 1'b1);
    print_verdict();
  end
endmodule : testbench
